// File: dbgseq_consts.vh
// constants for the debug event sequencer: register offsets,
// field positions, mode codes and reset values.
// assumes byte addressing on an 8-bit avalon address, one word per register.
`ifndef DBGSEQ_CONSTS_VH
`define DBGSEQ_CONSTS_VH

// ****************************************
// channel count and array indices
// ****************************************
`define DBGSEQ_NCH         11
`define DBGSEQ_CH1         0
`define DBGSEQ_CH2         1
`define DBGSEQ_CH3         2
`define DBGSEQ_CH4         3
`define DBGSEQ_CH5         4
`define DBGSEQ_CH11        10

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define DBGSEQ_OFS_ADDR0   8'h00
`define DBGSEQ_OFS_CTL0    8'h40
`define DBGSEQ_OFS_DATA1   8'h80
`define DBGSEQ_OFS_DATA2   8'h84
`define DBGSEQ_OFS_BUS1    8'h88
`define DBGSEQ_OFS_BUS2    8'h8C
`define DBGSEQ_OFS_COUNT   8'h90
`define DBGSEQ_OFS_SEQ     8'h94
`define DBGSEQ_OFS_STAT    8'h98
`define DBGSEQ_OFS_PERF    8'h9C
`define DBGSEQ_OFS_MCNT    8'hA0

// ****************************************
// channel control fields
// ****************************************
`define DBGSEQ_CTL_EN      0
`define DBGSEQ_CTL_SRC     2:1
`define DBGSEQ_CTL_BRK     3
`define DBGSEQ_CTL_TSTOP   4
`define DBGSEQ_CTL_TQUAL   5
`define DBGSEQ_SRC_DATA    2'h0
`define DBGSEQ_SRC_PC_PRE  2'h1
`define DBGSEQ_SRC_PC_POST 2'h2

// ****************************************
// data and bus-state fields (channels 1, 2)
// ****************************************
`define DBGSEQ_BUS_DEN     0
`define DBGSEQ_BUS_SIZE    2:1
`define DBGSEQ_BUS_RWEN    3
`define DBGSEQ_BUS_RWWR    4
`define DBGSEQ_SZ_BYTE     2'h0
`define DBGSEQ_SZ_WORD     2'h1

// ****************************************
// sequence control fields and modes
// ****************************************
`define DBGSEQ_SEQ_MODE    3:0
`define DBGSEQ_SEQ_WIN     5:4
`define DBGSEQ_M_NONE      4'h0
`define DBGSEQ_M_BRK321    4'h1
`define DBGSEQ_M_BRK321R   4'h2
`define DBGSEQ_M_BRK21     4'h3
`define DBGSEQ_M_BRK21R    4'h4
`define DBGSEQ_M_TRC321    4'h5
`define DBGSEQ_M_TRC321R   4'h6
`define DBGSEQ_M_TRC21     4'h7
`define DBGSEQ_M_TRC21R    4'h8
`define DBGSEQ_M_PERF21    4'h9
`define DBGSEQ_M_PERF12    4'hA
`define DBGSEQ_W_NONE      2'h0
`define DBGSEQ_W_BOUNDED_CAPTURE_WINDOW      2'h1
`define DBGSEQ_W_BOUNDED_CAPTURE_WINDOW_POR  2'h2

// ****************************************
// status bits and reset values
// ****************************************
`define DBGSEQ_ST_TSTOP    0
`define DBGSEQ_RST_CTL     6'h00
`define DBGSEQ_RST_BUS     5'h00
`define DBGSEQ_RST_SEQ     6'h00
`define DBGSEQ_RST_COUNT   16'h0000
`define DBGSEQ_RST_WORD    32'h00000000

`endif

// File: dbgseq_top.v
// debug event sequencer: eleven comparator channels, ordered sequencing,
// match count, bounded trace window and performance measurement.
// assumes observed bus and pc inputs are synchronous to i_clk_sys.
//
// What this block does
// - address compare uses data access address or pc before/after execution.
// - data compare on data bus with byte, word or longword size.
// - bus-state compare also requires matching read or write direction.
// - eleven channels; ch1 full, ch2 no count, ch3-11 address only.
// - count qualifier matches only after conditions met programmed number of times.
// - ch1 and ch2 may break, stop or qualify trace, bound performance.
// - ch4 and ch5 may break, stop trace, or bound the capture window.
// - ch3 and ch6-11 may only break or stop trace.
// - ch11 is the sequence reset point; the ch1 count sits in its own register.
// - ordered break mode breaks on order 3-2-1 or 2-1; a 3-2-1 mode entered from a 2-1 or unordered mode starts past the ch3 step.
// - ordered trace-stop mode halts trace without break on configured order.
// - without ordering no ordered condition and no performance start or end.
// - reset-point match discards sequence progress.
// - with ordering and count, act after sequence completes count times.
// - performance runs start to end channel, 2-to-1 or 1-to-2.
// - start after end restarts measurement; intervals accumulate.
// - capture window opens on ch5 match, closes on ch4 match.
// - power-on reset variant also closes the window on power-on reset.
// - ch5 match after a closed window reopens it.
// - power-on reset coinciding with a match satisfies nothing.
// - window and trace qualify both active are combined by and.
`timescale 1ns/100ps
`include "dbgseq_consts.vh"

module dbgseq_top
(
   // clock and reset
   input  wire        i_clk_sys,
   input  wire        i_rst_b,
   // avalon-mm slave
   input  wire [7:0]  i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [3:0]  i_byteenable,
   input  wire [31:0] i_writedata,
   output reg  [31:0] o_readdata,
   output reg         o_waitrequest,
   // observed activity
   input  wire        i_bus_valid,
   input  wire        i_bus_write,
   input  wire [31:0] i_bus_addr,
   input  wire [31:0] i_bus_data,
   input  wire        i_pc_valid,
   input  wire        i_pc_post,
   input  wire [31:0] i_pc_addr,
   input  wire        i_por,
   // actions
   output reg         o_break_req,
   output reg         o_trace_stopped,
   output reg         o_trace_capture,
   output reg         o_perf_running,
   output reg         o_window_open
);

   // ****************************************
   // sequence states
   // ****************************************
   localparam ST_WAIT3 = 2'h0;
   localparam ST_WAIT2 = 2'h1;
   localparam ST_WAIT1 = 2'h2;

   // ****************************************
   // functions
   // ****************************************
   function addr_hit;
      input [1:0]  src;
      input [31:0] ref_addr;
      input        bus_valid;
      input [31:0] bus_addr;
      input        pc_valid;
      input        pc_post;
      input [31:0] pc_addr;
      begin
         case (src)
            `DBGSEQ_SRC_DATA:    addr_hit = bus_valid & (bus_addr == ref_addr);
            `DBGSEQ_SRC_PC_PRE:  addr_hit = pc_valid & ~pc_post & (pc_addr == ref_addr);
            `DBGSEQ_SRC_PC_POST: addr_hit = pc_valid & pc_post & (pc_addr == ref_addr);
            default:             addr_hit = 1'b0;
         endcase
      end
   endfunction

   // channel 1/2 data and direction qualifiers
   function bus_ok;
      input [4:0]  cfg;
      input [31:0] ref_data;
      input        bus_valid;
      input        bus_write;
      input [31:0] bus_data;
      reg          d_ok;
      begin
         case (cfg[`DBGSEQ_BUS_SIZE])
            `DBGSEQ_SZ_BYTE: d_ok = bus_data[7:0] == ref_data[7:0];
            `DBGSEQ_SZ_WORD: d_ok = bus_data[15:0] == ref_data[15:0];
            default:         d_ok = bus_data == ref_data;
         endcase
         bus_ok = (~cfg[`DBGSEQ_BUS_DEN] | (bus_valid & d_ok))
            & (~cfg[`DBGSEQ_BUS_RWEN]
               | (bus_valid & (bus_write == cfg[`DBGSEQ_BUS_RWWR])));
      end
   endfunction

   function [31:0] be_merge;
      input [31:0] old_w;
      input [31:0] new_w;
      input [3:0]  be;
      integer      b;
      begin
         be_merge = old_w;
         for (b = 0; b < 4; b = b + 1)
            if (be[b])
               be_merge[b*8 +: 8] = new_w[b*8 +: 8];
      end
   endfunction

   // ****************************************
   // registers
   // ****************************************
   reg  [31:0] ch_addr_reg [0:`DBGSEQ_NCH-1];
   reg  [5:0]  ch_ctl_reg  [0:`DBGSEQ_NCH-1];
   reg  [31:0] data1_reg;
   reg  [31:0] data2_reg;
   reg  [4:0]  bus1_reg;
   reg  [4:0]  bus2_reg;
   reg  [15:0] count_reg;
   reg  [5:0]  seq_reg;
   reg  [15:0] mcnt_reg;
   reg  [15:0] mcnt_next;
   reg  [1:0]  stage_reg;
   reg  [1:0]  stage_next;
   reg  [31:0] perf_reg;
   reg  [31:0] rd_cur;
   reg  [10:0] hit;
   reg  [10:0] act_hit;
   reg         seq_done;
   integer     i;

   wire        wr_go = i_write & ~o_waitrequest;
   wire [3:0]  ch_idx = i_address[5:2];
   wire        ch_ok = (ch_idx < 4'hB);
   wire [31:0] wr_word = be_merge(rd_cur, i_writedata, i_byteenable);
   wire [3:0]  mode = seq_reg[`DBGSEQ_SEQ_MODE];
   wire [1:0]  win_mode = seq_reg[`DBGSEQ_SEQ_WIN];

   // ****************************************
   // mode decode
   // ****************************************
   wire seq_on = (mode >= `DBGSEQ_M_BRK321) && (mode <= `DBGSEQ_M_TRC21R);
   wire three = (mode == `DBGSEQ_M_BRK321) || (mode == `DBGSEQ_M_BRK321R)
      || (mode == `DBGSEQ_M_TRC321) || (mode == `DBGSEQ_M_TRC321R);
   wire rp_on = (mode == `DBGSEQ_M_BRK321R) || (mode == `DBGSEQ_M_BRK21R)
      || (mode == `DBGSEQ_M_TRC321R) || (mode == `DBGSEQ_M_TRC21R);
   wire seq_trc = seq_on && (mode >= `DBGSEQ_M_TRC321);
   wire perf_on = (mode == `DBGSEQ_M_PERF21) || (mode == `DBGSEQ_M_PERF12);
   wire win_on = (win_mode == `DBGSEQ_W_BOUNDED_CAPTURE_WINDOW) || (win_mode == `DBGSEQ_W_BOUNDED_CAPTURE_WINDOW_POR);
   wire [1:0] first_st = three ? ST_WAIT3 : ST_WAIT2;

   // ****************************************
   // channel comparators
   // ****************************************
   wire ch1_cond = hit[`DBGSEQ_CH1]
      & bus_ok(bus1_reg, data1_reg, i_bus_valid, i_bus_write, i_bus_data);
   wire ch2_cond = hit[`DBGSEQ_CH2]
      & bus_ok(bus2_reg, data2_reg, i_bus_valid, i_bus_write, i_bus_data);

   always @*
   begin
      for (i = 0; i < `DBGSEQ_NCH; i = i + 1)
         hit[i] = ch_ctl_reg[i][`DBGSEQ_CTL_EN] & ~i_por
            & addr_hit(ch_ctl_reg[i][`DBGSEQ_CTL_SRC], ch_addr_reg[i],
               i_bus_valid, i_bus_addr, i_pc_valid, i_pc_post, i_pc_addr);
   end

   // ****************************************
   // ordered sequence and match count
   // ****************************************
   // two-step modes never sit in the three-step first state
   wire [1:0] stage_cur = (!three && stage_reg == ST_WAIT3) ? ST_WAIT2 : stage_reg;

   always @*
   begin
      stage_next = stage_cur;
      seq_done = 1'b0;
      if (!seq_on)
         stage_next = first_st;
      else if (rp_on && hit[`DBGSEQ_CH11])
         stage_next = first_st;
      else
         case (stage_cur)
            ST_WAIT3: if (hit[`DBGSEQ_CH3]) stage_next = ST_WAIT2;
            ST_WAIT2: if (ch2_cond) stage_next = ST_WAIT1;
            ST_WAIT1:
            begin
               if (ch1_cond)
               begin
                  seq_done = 1'b1;
                  stage_next = first_st;
               end
            end
            default: stage_next = first_st;
         endcase
   end

   // count applies to whole sequences when ordering is on
   wire cnt_in = seq_on ? seq_done : ch1_cond;
   wire cnt_fire = cnt_in & ((count_reg <= 16'h0001)
      | (mcnt_reg == count_reg - 16'h0001));
   wire ch1_match = ~seq_on & cnt_fire;
   wire seq_fire = seq_on & cnt_fire;

   always @*
   begin
      mcnt_next = mcnt_reg;
      if (cnt_in)
         mcnt_next = cnt_fire ? 16'h0000 : mcnt_reg + 16'h0001;
   end

   // ****************************************
   // per-channel actions
   // ****************************************
   // channels owned by a combined function lose their own actions
   always @*
   begin
      act_hit = hit;
      act_hit[`DBGSEQ_CH1] = ch1_match;
      act_hit[`DBGSEQ_CH2] = ch2_cond;
      if (seq_on || perf_on)
      begin
         act_hit[`DBGSEQ_CH1] = 1'b0;
         act_hit[`DBGSEQ_CH2] = 1'b0;
         act_hit[`DBGSEQ_CH3] = 1'b0;
      end
      if (rp_on)
         act_hit[`DBGSEQ_CH11] = 1'b0;
      if (win_on)
      begin
         act_hit[`DBGSEQ_CH4] = 1'b0;
         act_hit[`DBGSEQ_CH5] = 1'b0;
      end
   end

   reg [10:0] brk_en;
   reg [10:0] stop_en;
   always @*
   begin
      for (i = 0; i < `DBGSEQ_NCH; i = i + 1)
      begin
         brk_en[i] = ch_ctl_reg[i][`DBGSEQ_CTL_BRK];
         stop_en[i] = ch_ctl_reg[i][`DBGSEQ_CTL_TSTOP];
      end
   end

   wire brk_now = (|(act_hit & brk_en)) | (seq_fire & ~seq_trc);
   wire stop_now = (|(act_hit & stop_en)) | (seq_fire & seq_trc);

   // trace qualify exists only on channels 1 and 2
   wire q1 = ch_ctl_reg[`DBGSEQ_CH1][`DBGSEQ_CTL_TQUAL] & ~seq_on & ~perf_on;
   wire q2 = ch_ctl_reg[`DBGSEQ_CH2][`DBGSEQ_CTL_TQUAL] & ~seq_on & ~perf_on;
   wire qual_hit = (q1 & ch1_match) | (q2 & ch2_cond);

   // ****************************************
   // capture window and trace gating
   // ****************************************
   wire win_close = hit[`DBGSEQ_CH4]
      | (i_por & (win_mode == `DBGSEQ_W_BOUNDED_CAPTURE_WINDOW_POR));
   wire win_next = win_on & ~win_close
      & (o_window_open | hit[`DBGSEQ_CH5]);
   wire win_ok = ~win_on | o_window_open | hit[`DBGSEQ_CH5];
   wire entry = i_bus_valid | i_pc_valid;
   wire cap_now = entry & ~o_trace_stopped & ~stop_now & win_ok
      & (~(q1 | q2) | qual_hit);

   // ****************************************
   // performance measurement
   // ****************************************
   wire p_start = (mode == `DBGSEQ_M_PERF21) ? ch2_cond : ch1_match;
   wire p_end = (mode == `DBGSEQ_M_PERF21) ? ch1_match : ch2_cond;
   wire perf_next = perf_on & (o_perf_running ? ~p_end : p_start);

   // ****************************************
   // register read view
   // ****************************************
   always @*
   begin
      rd_cur = `DBGSEQ_RST_WORD;
      if (i_address[7:6] == 2'h0 && ch_ok)
         rd_cur = ch_addr_reg[ch_idx];
      else if (i_address[7:6] == 2'h1 && ch_ok)
         rd_cur = {26'h0000000, ch_ctl_reg[ch_idx]};
      else
         case (i_address)
            `DBGSEQ_OFS_DATA1: rd_cur = data1_reg;
            `DBGSEQ_OFS_DATA2: rd_cur = data2_reg;
            `DBGSEQ_OFS_BUS1:  rd_cur = {27'h0000000, bus1_reg};
            `DBGSEQ_OFS_BUS2:  rd_cur = {27'h0000000, bus2_reg};
            `DBGSEQ_OFS_COUNT: rd_cur = {16'h0000, count_reg};
            `DBGSEQ_OFS_SEQ:   rd_cur = {26'h0000000, seq_reg};
            `DBGSEQ_OFS_STAT:  rd_cur = {26'h0000000, stage_reg,
               o_window_open, o_perf_running, o_break_req, o_trace_stopped};
            `DBGSEQ_OFS_PERF:  rd_cur = perf_reg;
            `DBGSEQ_OFS_MCNT:  rd_cur = {16'h0000, mcnt_reg};
            default:           rd_cur = `DBGSEQ_RST_WORD;
         endcase
   end

   // ****************************************
   // bus handshake
   // ****************************************
   // one wait cycle per access keeps read data a plain register
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
      begin
         o_waitrequest <= 1'b1;
         o_readdata <= `DBGSEQ_RST_WORD;
      end
      else
      begin
         o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
         if (i_read & o_waitrequest)
            o_readdata <= rd_cur;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   // host keeps configuration quiet while the target is in reset
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
      begin
         for (i = 0; i < `DBGSEQ_NCH; i = i + 1)
         begin
            ch_addr_reg[i] <= `DBGSEQ_RST_WORD;
            ch_ctl_reg[i] <= `DBGSEQ_RST_CTL;
         end
         data1_reg <= `DBGSEQ_RST_WORD;
         data2_reg <= `DBGSEQ_RST_WORD;
         bus1_reg <= `DBGSEQ_RST_BUS;
         bus2_reg <= `DBGSEQ_RST_BUS;
         count_reg <= `DBGSEQ_RST_COUNT;
         seq_reg <= `DBGSEQ_RST_SEQ;
      end
      else if (wr_go)
      begin
         if (i_address[7:6] == 2'h0 && ch_ok)
            ch_addr_reg[ch_idx] <= wr_word;
         else if (i_address[7:6] == 2'h1 && ch_ok)
            ch_ctl_reg[ch_idx] <= wr_word[5:0];
         else
            case (i_address)
               `DBGSEQ_OFS_DATA1: data1_reg <= wr_word;
               `DBGSEQ_OFS_DATA2: data2_reg <= wr_word;
               `DBGSEQ_OFS_BUS1:  bus1_reg <= wr_word[4:0];
               `DBGSEQ_OFS_BUS2:  bus2_reg <= wr_word[4:0];
               `DBGSEQ_OFS_COUNT: count_reg <= wr_word[15:0];
               `DBGSEQ_OFS_SEQ:   seq_reg <= wr_word[5:0];
               default:           count_reg <= count_reg;
            endcase
      end
   end

   // ****************************************
   // event state and outputs
   // ****************************************
   wire stat_clr = wr_go & (i_address == `DBGSEQ_OFS_STAT)
      & i_byteenable[0] & i_writedata[`DBGSEQ_ST_TSTOP];
   wire perf_clr = wr_go & (i_address == `DBGSEQ_OFS_PERF);

   // reset leaves every channel idle until the host programs it
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
      begin
         stage_reg <= ST_WAIT3;
         mcnt_reg <= `DBGSEQ_RST_COUNT;
         perf_reg <= `DBGSEQ_RST_WORD;
         o_break_req <= 1'b0;
         o_trace_stopped <= 1'b0;
         o_trace_capture <= 1'b0;
         o_perf_running <= 1'b0;
         o_window_open <= 1'b0;
      end
      else
      begin
         stage_reg <= stage_next;
         mcnt_reg <= mcnt_next;
         o_break_req <= brk_now;
         // a stop arriving with the clear wins
         o_trace_stopped <= stop_now | (o_trace_stopped & ~stat_clr);
         o_trace_capture <= cap_now;
         o_perf_running <= perf_next;
         o_window_open <= win_next;
         // intervals add up; only a write to the perf register or reset zeroes the total
         if (perf_clr)
            perf_reg <= `DBGSEQ_RST_WORD;
         else if (o_perf_running)
            perf_reg <= perf_reg + 32'h00000001;
      end
   end

endmodule

// File: dbgseq_chk.sv
// checker for the debug event sequencer, bound to its top module.
// assumes only the top module ports are visible; config state is not.
`timescale 1ns/100ps

module dbgseq_chk
(
   // clock and reset
   input logic        i_clk_sys,
   input logic        i_rst_b,
   // register bus
   input logic [7:0]  i_address,
   input logic        i_read,
   input logic        i_write,
   input logic [3:0]  i_byteenable,
   input logic [31:0] i_writedata,
   input logic        o_waitrequest,
   // observed activity
   input logic        i_bus_valid,
   input logic        i_pc_valid,
   input logic        i_por,
   // actions
   input logic        o_break_req,
   input logic        o_trace_stopped,
   input logic        o_trace_capture,
   input logic        o_perf_running,
   input logic        o_window_open
);
   wire ev_any = i_pc_valid | i_bus_valid;
   // clear write to status bit 0, lane 0 only
   wire stat_clr = i_write & ~o_waitrequest & (i_address[7:2] == 6'h26)
                   & i_byteenable[0] & i_writedata[0];

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   // ****
   // properties
   // ****
   property p_por_no_break; i_por |=> !o_break_req; endproperty
   property p_break_cause; o_break_req |-> $past(ev_any & ~i_por); endproperty
   property p_stop_set; $rose(o_trace_stopped) |-> $past(ev_any & ~i_por); endproperty
   property p_stop_hold; $fell(o_trace_stopped) |-> !$past(i_rst_b) || $past(stat_clr);
   endproperty
   property p_win_open; $rose(o_window_open) |-> $past(ev_any & ~i_por); endproperty
   property p_win_close;
      $fell(o_window_open) |-> !$past(i_rst_b) || $past(ev_any | i_por | i_write);
   endproperty
   property p_perf_start; $rose(o_perf_running) |-> $past(ev_any & ~i_por); endproperty
   property p_cap_halt; o_trace_stopped && $past(o_trace_stopped) |-> !o_trace_capture;
   endproperty
   // exactly one wait cycle per access
   property p_wait_one; !o_waitrequest |=> o_waitrequest; endproperty
   property p_wait_ans; (i_read | i_write) && o_waitrequest |=> !o_waitrequest; endproperty

   a_por_no_break:
   assert property (p_por_no_break) else $error("break after por");
   a_break_cause:
   assert property (p_break_cause) else $error("stray break");
   a_stop_set:
   assert property (p_stop_set) else $error("stray stop");
   a_stop_hold:
   assert property (p_stop_hold) else $error("stop lost");
   a_win_open:
   assert property (p_win_open) else $error("stray open");
   a_win_close:
   assert property (p_win_close) else $error("stray close");
   a_perf_start:
   assert property (p_perf_start) else $error("stray perf");
   a_cap_halt:
   assert property (p_cap_halt) else $error("capture when stopped");
   a_wait_one:
   assert property (p_wait_one) else $error("wait low too long");
   a_wait_ans:
   assert property (p_wait_ans) else $error("no answer");

   c_brk: cover property (o_break_req);
   c_win: cover property ($fell(o_window_open));
   c_perf: cover property ($fell(o_perf_running));
endmodule

bind dbgseq_top dbgseq_chk u_chk (.i_clk_sys, .i_rst_b, .i_address, .i_read, .i_write,
   .i_byteenable, .i_writedata, .o_waitrequest, .i_bus_valid, .i_pc_valid, .i_por,
   .o_break_req, .o_trace_stopped, .o_trace_capture, .o_perf_running, .o_window_open);

// File: dbgseq_core_model.sv
// model of the processor core and bus masters watched by the sequencer.
// assumes the bench calls ev() one event at a time from a clock edge.
`timescale 1ns/100ps

module dbgseq_core_model
(
   // clock
   input  logic        i_clk_sys,
   // observed activity
   output logic        o_bus_valid = 1'b0,
   output logic        o_bus_write = 1'b0,
   output logic [31:0] o_bus_addr  = 32'h0,
   output logic [31:0] o_bus_data  = 32'h0,
   output logic        o_pc_valid  = 1'b0,
   output logic        o_pc_post   = 1'b0,
   output logic [31:0] o_pc_addr   = 32'h0,
   output logic        o_por       = 1'b0
);
   // one event cycle, one idle cycle: keeps sequence steps apart
   task ev(input logic pv, input logic pp, input logic bv, input logic bw,
           input logic [31:0] a, input logic [31:0] d, input logic pr);
      @(posedge i_clk_sys);
      o_pc_valid  <= pv;
      o_pc_post   <= pp;
      o_bus_valid <= bv;
      o_bus_write <= bw;
      o_bus_addr  <= a;
      o_pc_addr   <= a;
      o_bus_data  <= d;
      o_por       <= pr; // lone pulse, host stays quiet meanwhile
      @(posedge i_clk_sys);
      // released lines flip so stale values never match by chance
      o_pc_valid  <= 1'b0;
      o_bus_valid <= 1'b0;
      o_por       <= 1'b0;
      o_bus_addr  <= ~a;
      o_pc_addr   <= ~a;
      o_bus_data  <= ~d;
      o_bus_write <= ~bw;
      o_pc_post   <= ~pp;
   endtask
endmodule

// File: tb_top.sv
// self-checking bench for the debug event sequencer.
// assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "dbgseq_consts.vh"
`define CHK(g,e,m) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %0t %s", $time, m); end end

module tb_top;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        i_read = 1'b0;
   logic        i_write = 1'b0;
   logic [7:0]  i_address = 8'h00;
   logic [3:0]  i_byteenable = 4'hF;
   logic [31:0] i_writedata = 32'h00000000;
   logic [31:0] rd, p1;
   wire  [31:0] o_readdata, i_bus_addr, i_bus_data, i_pc_addr;
   wire         o_waitrequest, o_break_req, o_trace_stopped, o_trace_capture, i_por;
   wire         o_perf_running, o_window_open, i_bus_valid, i_bus_write, i_pc_valid, i_pc_post;
   int          num_errors = 0, compares = 0, brk_cnt = 0, brk_ref = 0;

   always #25 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) if (o_break_req === 1'b1) brk_cnt <= brk_cnt + 1;

   dbgseq_top u_dut (.i_clk_sys, .i_rst_b, .i_address, .i_read, .i_write, .i_byteenable,
      .i_writedata, .o_readdata, .o_waitrequest, .i_bus_valid, .i_bus_write, .i_bus_addr,
      .i_bus_data, .i_pc_valid, .i_pc_post, .i_pc_addr, .i_por, .o_break_req,
      .o_trace_stopped, .o_trace_capture, .o_perf_running, .o_window_open);
   dbgseq_core_model u_core (.i_clk_sys, .o_bus_valid(i_bus_valid),
      .o_bus_write(i_bus_write), .o_bus_addr(i_bus_addr), .o_bus_data(i_bus_data),
      .o_pc_valid(i_pc_valid), .o_pc_post(i_pc_post), .o_pc_addr(i_pc_addr), .o_por(i_por));

   // ****
   // tasks
   // ****
   task final_report;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // held until waitrequest is sampled low at a rising edge; only the watchdog ends a hang
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_address   <= a;
      i_writedata <= d;
      i_write     <= w;
      i_read      <= !w;
      do @(posedge i_clk_sys); while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_write <= 1'b0;
      i_read  <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d); acc(1'b1, a, d); endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      acc(1'b0, a, 32'h00000000);
      `CHK(rd, e, m)
   endtask
   task pc(input logic [31:0] a); u_core.ev(1'b1, 1'b0, 1'b0, 1'b0, a, 32'h0, 1'b0); endtask
   task pcp(input logic [31:0] a); u_core.ev(1'b1, 1'b1, 1'b0, 1'b0, a, 32'h0, 1'b0); endtask
   task bus(input logic w, input logic [31:0] d);
      u_core.ev(1'b0, 1'b0, 1'b1, w, 32'h00000100, d, 1'b0);
   endtask
   task brk_is(input int n, input string m);
      repeat (2) @(negedge i_clk_sys);
      `CHK(brk_cnt - brk_ref, n, m)
      brk_ref = brk_cnt;
   endtask
   // {stopped, perf, window} after the edge lands
   task st(input logic [2:0] e, input string m);
      @(negedge i_clk_sys);
      `CHK({o_trace_stopped, o_perf_running, o_window_open}, e, m)
   endtask

   // ****
   // tests
   // ****
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      num_errors++;
      final_report;
   end

   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      rdc(8'h94, 32'h0, "seq reset value");
      wr(8'hFC, 32'hFFFFFFFF);
      rdc(8'hFC, 32'h0, "unmapped read");
      for (int k = 0; k < 11; k++) begin
         wr(8'(k * 4), 32'(k + 1) << 8);
         wr(8'(8'h40 + k * 4), 32'h00000003);
      end
      rdc(8'h28, 32'h00000B00, "ch11 address");
      wr(8'h94, `DBGSEQ_M_BRK321);
      pc(32'h100); pc(32'h200); pc(32'h300); brk_is(0, "wrong order");
      pc(32'h200); pc(32'h100); brk_is(1, "order 3-2-1");
      wr(8'h94, `DBGSEQ_M_BRK21);
      pc(32'h100); pc(32'h200); pc(32'h100); brk_is(1, "order 2-1");
      wr(8'h94, `DBGSEQ_M_BRK321R);
      pc(32'h300); pc(32'h200); pc(32'hB00); pc(32'h100); brk_is(0, "reset point");
      pc(32'h300); pc(32'h200); pc(32'h100); brk_is(1, "after reset point");
      wr(8'h90, 32'h2);
      wr(8'h94, `DBGSEQ_M_BRK21);
      pc(32'h200); pc(32'h100); brk_is(0, "seq count 1 of 2");
      pc(32'h200); pc(32'h100); brk_is(1, "seq count 2 of 2");
      wr(8'h90, 32'h0);
      wr(8'h94, `DBGSEQ_M_TRC21);
      pc(32'h200); pc(32'h100); brk_is(0, "trace stop no break");
      st(3'b100, "trace stopped");
      wr(8'h98, 32'h1);
      st(3'b000, "trace stop cleared");
      wr(8'h94, `DBGSEQ_M_PERF21);
      pc(32'h200); st(3'b010, "perf 2 to 1 start");
      pc(32'h100); st(3'b000, "perf 2 to 1 end");
      acc(1'b0, 8'h9C, 32'h0);
      p1 = rd;
      pc(32'h200); pc(32'h100); acc(1'b0, 8'h9C, 32'h0);
      `CHK(rd > p1, 1'b1, "perf accumulates")
      wr(8'h94, `DBGSEQ_M_PERF12);
      pc(32'h100); st(3'b010, "perf 1 to 2 start");
      pc(32'h200); st(3'b000, "perf 1 to 2 end");
      wr(8'h94, `DBGSEQ_M_NONE);
      pc(32'h200); st(3'b000, "no mode no perf");
      pc(32'h100); brk_is(0, "no mode no break");
      // lone channel actions
      wr(8'h54, 32'h0000000B);
      pc(32'h600); brk_is(1, "ch6 break");
      wr(8'h4C, 32'h00000013);
      pc(32'h400); st(3'b100, "ch4 trace stop");
      wr(8'h98, 32'h1);
      wr(8'h4C, 32'h00000003);
      wr(8'h54, 32'h00000003);
      wr(8'h94, 32'h00000010);
      pc(32'h500); st(3'b001, "window open");
      `CHK(o_trace_capture, 1'b1, "capture in window")
      pc(32'h400); st(3'b000, "window closed");
      pc(32'h500); st(3'b001, "window reopened");
      pc(32'h400);
      wr(8'h94, 32'h00000020);
      pc(32'h500);
      u_core.ev(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0, 1'b1);
      st(3'b000, "window closed by por");
      u_core.ev(1'b1, 1'b0, 1'b0, 1'b0, 32'h500, 32'h0, 1'b1);
      st(3'b000, "match with por ignored");
      `CHK(o_trace_capture, 1'b0, "no capture outside window")
      wr(8'h94, 32'h0);
      // channel 1 data and direction qualifiers
      wr(8'h40, 32'h00000009);
      wr(8'h80, 32'h12345678);
      wr(8'h88, 32'h0000001D);
      bus(1'b1, 32'h12345678); brk_is(1, "data write match");
      bus(1'b0, 32'h12345678); brk_is(0, "wrong direction");
      bus(1'b1, 32'h12345679); brk_is(0, "data mismatch");
      wr(8'h88, 32'h00000019);
      bus(1'b1, 32'hAAAAAA78); brk_is(1, "byte size match");
      wr(8'h88, 32'h0);
      wr(8'h40, 32'h0000000D);
      pc(32'h100); brk_is(0, "pc before ignored");
      pcp(32'h100); brk_is(1, "pc after match");
      wr(8'h90, 32'h2);
      pcp(32'h100); brk_is(0, "count 1 of 2");
      pcp(32'h100); brk_is(1, "count 2 of 2");
      final_report;
   end
endmodule
